// ===== logic/lmx_consts.svh
// Purpose: constants of the literal and indirect move execution block
// Assumes: 14-bit instruction words, one instruction per ref_clk cycle
// Notes: opcode patterns are matched as (word & mask) == pattern
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH

// ****************************************************************
// opcode patterns and masks
// ****************************************************************
`define LMX_PAT_IDLE 14'h0000
`define LMX_PAT_SWRESET 14'h0001
`define LMX_PAT_OPTION 14'h0062
`define LMX_MSK_EXACT 14'h3FFF
`define LMX_PAT_BANK 14'h0020
`define LMX_MSK_BANK 14'h3FE0
`define LMX_PAT_PAGE 14'h3180
`define LMX_MSK_PAGE 14'h3F80
`define LMX_PAT_ACC 14'h3000
`define LMX_MSK_ACC 14'h3F00
`define LMX_PAT_DIRECT 14'h0080
`define LMX_MSK_DIRECT 14'h3F80
`define LMX_PAT_IND_MODE 14'h0018
`define LMX_MSK_IND_MODE 14'h3FF8
`define LMX_PAT_IND_OFF 14'h3F80
`define LMX_MSK_IND_OFF 14'h3F80

// ****************************************************************
// operand field positions
// ****************************************************************
`define LMX_BANK_MSB 4
`define LMX_PAGE_MSB 6
`define LMX_ACC_MSB 7
`define LMX_FADDR_MSB 6
`define LMX_MODE_MSB 1
`define LMX_IND_SEL_MODE_BIT 2
`define LMX_IND_SEL_OFF_BIT 6
`define LMX_OFF_MSB 5

// ****************************************************************
// window addresses and reset values
// ****************************************************************
`define LMX_WINDOW0_ADDR 7'h00
`define LMX_WINDOW1_ADDR 7'h01
`define LMX_RST_ACC 8'h00
`define LMX_RST_BANK 5'h00
`define LMX_RST_PAGE 7'h00
`define LMX_RST_OPTION 8'hFF
`define LMX_RST_PTR 16'h0000
`define LMX_RST_STATUS 8'h00
`define LMX_RST_RI_FLAG 1'b1

`endif

// ===== logic/lmx_pkg.sv
// Purpose: types shared by the move execution block
// Assumes: constants come from lmx_consts.svh
// Notes: none
package lmx_pkg;

    // ****************************************************************
    // instruction classes
    // ****************************************************************
    typedef enum logic [3:0] {
        LMX_OP_NONE = 4'b0000,
        LMX_OP_IDLE = 4'b0001,
        LMX_OP_SWRESET = 4'b0010,
        LMX_OP_OPTION = 4'b0011,
        LMX_OP_BANK = 4'b0100,
        LMX_OP_PAGE = 4'b0101,
        LMX_OP_ACC = 4'b0110,
        LMX_OP_DIRECT = 4'b0111,
        LMX_OP_IND_MODE = 4'b1000,
        LMX_OP_IND_OFF = 4'b1001,
        LMX_OP_OTHER = 4'b1010
    } lmx_op_e;

    // pointer update modes
    typedef enum logic [1:0] {
        LMX_PREINC = 2'b00,
        LMX_PREDEC = 2'b01,
        LMX_POSTINC = 2'b10,
        LMX_POSTDEC = 2'b11
    } lmx_mode_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } lmx_instr_s;

    typedef struct packed {
        logic strobe;
        logic [15:0] addr;
        logic [7:0] data;
    } lmx_write_s;

endpackage : lmx_pkg

// ===== logic/lmx_ptr_unit.sv
// Purpose: effective address and next value of an indirect pointer
// Assumes: purely combinational, 16-bit pointer
// Notes: arithmetic is modulo 2^16 so both ends wrap
`timescale 1ns/1ps
module lmx_ptr_unit (
    input wire logic [15:0] ptr,
    input wire lmx_pkg::lmx_mode_e pointer_update_mode,
    input wire logic use_offset,
    input wire logic [5:0] offset,
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_next
);
    import lmx_pkg::*;

    // wrapping add of a signed delta
    function automatic logic [15:0] add_wrap(input logic [15:0] a, input logic [15:0] d);
        add_wrap = 16'(a + d);
    endfunction : add_wrap

    // ****************************************************************
    // address and update selection
    // ****************************************************************
    always_comb begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (use_offset) begin
            eff_addr = add_wrap(ptr, {{10{offset[5]}}, offset});
        end else begin
            unique case (pointer_update_mode)
                LMX_PREINC: begin
                    eff_addr = add_wrap(ptr, 16'h0001);
                    ptr_next = add_wrap(ptr, 16'h0001);
                end
                LMX_PREDEC: begin
                    eff_addr = add_wrap(ptr, 16'hFFFF);
                    ptr_next = add_wrap(ptr, 16'hFFFF);
                end
                LMX_POSTINC: ptr_next = add_wrap(ptr, 16'h0001);
                LMX_POSTDEC: ptr_next = add_wrap(ptr, 16'hFFFF);
            endcase
        end
    end

endmodule : lmx_ptr_unit

// ===== logic/lmx_exec.sv
// Purpose: execution of literal, direct and indirect moves of an 8-bit core
// Assumes: one instruction word per ref_clk cycle, from same-clock fetch logic
// Notes: all effects appear at the edge that takes the instruction, except the soft reset clear, which comes one edge later
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_exec (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire lmx_pkg::lmx_instr_s instr_in,
    input wire logic status_wr_en,
    input wire logic [7:0] status_wr_data,
    input wire logic ri_flag_set,
    output logic [7:0] acc_reg,
    output logic [4:0] bank_select_reg,
    output logic [6:0] program_high_latch,
    output logic [7:0] prescaler_cfg_reg,
    output logic [15:0] ptr0_reg,
    output logic [15:0] ptr1_reg,
    output logic [7:0] status_reg,
    output logic reset_instruction_flag,
    output lmx_pkg::lmx_write_s file_wr_reg,
    output logic pc_advance_reg,
    output logic device_reset_reg
);
    import lmx_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                                 input logic [13:0] p);
        hit = (w & m) == p;
    endfunction : hit

    lmx_op_e op;
    logic [13:0] w;
    logic soft_rst;
    logic rst_all;

    assign w = instr_in.word;
    assign soft_rst = device_reset_reg;
    assign rst_all = sys_rst | soft_rst;

    // classify the current word
    always_comb begin
        op = LMX_OP_NONE;
        if (!instr_in.valid || soft_rst) begin
            op = LMX_OP_NONE;
        end else if (hit(w, `LMX_MSK_EXACT, `LMX_PAT_IDLE)) begin
            op = LMX_OP_IDLE;
        end else if (hit(w, `LMX_MSK_EXACT, `LMX_PAT_SWRESET)) begin
            op = LMX_OP_SWRESET;
        end else if (hit(w, `LMX_MSK_EXACT, `LMX_PAT_OPTION)) begin
            op = LMX_OP_OPTION;
        end else if (hit(w, `LMX_MSK_BANK, `LMX_PAT_BANK)) begin
            op = LMX_OP_BANK;
        end else if (hit(w, `LMX_MSK_ACC, `LMX_PAT_ACC)) begin
            op = LMX_OP_ACC;
        end else if (hit(w, `LMX_MSK_PAGE, `LMX_PAT_PAGE)) begin
            op = LMX_OP_PAGE;
        end else if (hit(w, `LMX_MSK_DIRECT, `LMX_PAT_DIRECT)) begin
            op = LMX_OP_DIRECT;
        end else if (hit(w, `LMX_MSK_IND_MODE, `LMX_PAT_IND_MODE)) begin
            op = LMX_OP_IND_MODE;
        end else if (hit(w, `LMX_MSK_IND_OFF, `LMX_PAT_IND_OFF)) begin
            op = LMX_OP_IND_OFF;
        end else begin
            op = LMX_OP_OTHER;
        end
    end

    // ****************************************************************
    // indirect address path
    // ****************************************************************
    logic ptr_sel;
    logic [15:0] ptr_cur;
    logic [15:0] eff_addr;
    logic [15:0] ptr_next;
    logic [6:0] faddr;
    logic [15:0] direct_addr;

    assign ptr_sel = (op == LMX_OP_IND_OFF) ? w[`LMX_IND_SEL_OFF_BIT]
                                            : w[`LMX_IND_SEL_MODE_BIT];
    assign ptr_cur = ptr_sel ? ptr1_reg : ptr0_reg;
    assign faddr = w[`LMX_FADDR_MSB:0];

    lmx_ptr_unit u_ptr (
        .ptr(ptr_cur),
        .pointer_update_mode(lmx_mode_e'(w[`LMX_MODE_MSB:0])),
        .use_offset(op == LMX_OP_IND_OFF),
        .offset(w[`LMX_OFF_MSB:0]),
        .eff_addr(eff_addr),
        .ptr_next(ptr_next)
    );

    // window addresses have no storage: go through the pointer
    always_comb begin
        direct_addr = {9'h000, faddr};
        if (faddr == `LMX_WINDOW0_ADDR) begin
            direct_addr = ptr0_reg;
        end else if (faddr == `LMX_WINDOW1_ADDR) begin
            direct_addr = ptr1_reg;
        end
    end

    // ****************************************************************
    // architectural registers
    // ****************************************************************
    // accumulator literal load
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            acc_reg <= `LMX_RST_ACC;
        end else if (op == LMX_OP_ACC) begin
            acc_reg <= w[`LMX_ACC_MSB:0];
        end
    end

    // bank select load
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            bank_select_reg <= `LMX_RST_BANK;
        end else if (op == LMX_OP_BANK) begin
            bank_select_reg <= w[`LMX_BANK_MSB:0];
        end
    end

    // program counter high latch load
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            program_high_latch <= `LMX_RST_PAGE;
        end else if (op == LMX_OP_PAGE) begin
            program_high_latch <= w[`LMX_PAGE_MSB:0];
        end
    end

    // prescaler configuration load
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            prescaler_cfg_reg <= `LMX_RST_OPTION;
        end else if (op == LMX_OP_OPTION) begin
            prescaler_cfg_reg <= acc_reg;
        end
    end

    // pointer updates, wrapping modulo 2^16
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            ptr0_reg <= `LMX_RST_PTR;
            ptr1_reg <= `LMX_RST_PTR;
        end else if (op == LMX_OP_IND_MODE) begin
            if (ptr_sel) begin
                ptr1_reg <= ptr_next;
            end else begin
                ptr0_reg <= ptr_next;
            end
        end
    end

    // status is written only by the alu; moves never touch it
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            status_reg <= `LMX_RST_STATUS;
        end else if (status_wr_en) begin
            status_reg <= status_wr_data;
        end
    end

    // file register write port
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            file_wr_reg <= '0;
        end else begin
            file_wr_reg.strobe <= (op == LMX_OP_DIRECT) || (op == LMX_OP_IND_MODE)
                                  || (op == LMX_OP_IND_OFF);
            file_wr_reg.data <= acc_reg;
            file_wr_reg.addr <= (op == LMX_OP_DIRECT) ? direct_addr : eff_addr;
        end
    end

    // at most one instruction retires per cycle; the soft reset word does not retire
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            pc_advance_reg <= 1'b0;
        end else begin
            pc_advance_reg <= (op != LMX_OP_NONE) && (op != LMX_OP_SWRESET);
        end
    end

    // software reset pulse, one cycle wide
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            device_reset_reg <= 1'b0;
        end else begin
            device_reset_reg <= (op == LMX_OP_SWRESET);
        end
    end

    // reset cause flag: survives the soft reset, instruction clear wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reset_instruction_flag <= `LMX_RST_RI_FLAG;
        end else if (op == LMX_OP_SWRESET) begin
            reset_instruction_flag <= 1'b0;
        end else if (ri_flag_set) begin
            reset_instruction_flag <= 1'b1;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    // only the pin reset disables: rst_all would hide the soft reset pulse itself
    default disable iff (sys_rst);

    // literal loads land one edge after the word
    a_bank_load: assert property (op == LMX_OP_BANK |=> bank_select_reg == $past(w[4:0]))
        else $error("bank select not loaded");
    a_page_load: assert property (op == LMX_OP_PAGE |=> program_high_latch == $past(w[6:0]))
        else $error("page latch not loaded");
    a_acc_load: assert property (op == LMX_OP_ACC |=> acc_reg == $past(w[7:0]))
        else $error("accumulator not loaded");

    // stores: direct, window and indirect
    a_direct_store: assert property ((op == LMX_OP_DIRECT) && (faddr > 7'h01)
        |=> file_wr_reg.strobe && file_wr_reg.addr == {9'h000, $past(faddr)}
            && file_wr_reg.data == $past(acc_reg))
        else $error("direct store wrong");
    a_offset_store: assert property (op == LMX_OP_IND_OFF
        |=> file_wr_reg.addr == 16'($past(ptr_cur) + {{10{$past(w[5])}}, $past(w[5:0])})
            && $stable(ptr0_reg) && $stable(ptr1_reg))
        else $error("offset store wrong");
    a_ind_data: assert property ((op == LMX_OP_IND_MODE) || (op == LMX_OP_IND_OFF)
        |=> file_wr_reg.strobe && file_wr_reg.data == $past(acc_reg))
        else $error("indirect store data wrong");
    a_preinc_mode: assert property ((op == LMX_OP_IND_MODE) && (w[1:0] == 2'b00) && !ptr_sel
        |=> ptr0_reg == 16'($past(ptr0_reg) + 16'h0001) && file_wr_reg.addr == ptr0_reg)
        else $error("preincrement wrong");
    a_predec_mode: assert property ((op == LMX_OP_IND_MODE) && (w[1:0] == 2'b01) && !ptr_sel
        |=> ptr0_reg == 16'($past(ptr0_reg) - 16'h0001) && file_wr_reg.addr == ptr0_reg
            && $stable(ptr1_reg))
        else $error("predecrement wrong");
    a_postinc_mode: assert property ((op == LMX_OP_IND_MODE) && (w[1:0] == 2'b10) && ptr_sel
        |=> ptr1_reg == 16'($past(ptr1_reg) + 16'h0001)
            && file_wr_reg.addr == $past(ptr1_reg) && $stable(ptr0_reg))
        else $error("postincrement wrong");
    a_postdec_mode: assert property ((op == LMX_OP_IND_MODE) && (w[1:0] == 2'b11) && ptr_sel
        |=> ptr1_reg == 16'($past(ptr1_reg) - 16'h0001)
            && file_wr_reg.addr == $past(ptr1_reg))
        else $error("postdecrement wrong");
    a_window_redirect: assert property ((op == LMX_OP_DIRECT) && (faddr == `LMX_WINDOW1_ADDR)
        |=> file_wr_reg.addr == $past(ptr1_reg))
        else $error("window not redirected");
    a_window0_redirect: assert property ((op == LMX_OP_DIRECT) && (faddr == `LMX_WINDOW0_ADDR)
        |=> file_wr_reg.addr == $past(ptr0_reg) && $stable(ptr0_reg))
        else $error("window 0 not redirected");

    // pointer wrap and status isolation
    a_ptr_wrap: assert property ((op == LMX_OP_IND_MODE) && !ptr_sel && (ptr0_reg == 16'hFFFF)
        && (w[1:0] == 2'b10) |=> ptr0_reg == 16'h0000)
        else $error("pointer did not wrap");
    a_status_kept: assert property (!status_wr_en && !soft_rst |=> $stable(status_reg))
        else $error("status changed by a move");

    // option, reset, idle and unclassified words
    a_option_load: assert property (op == LMX_OP_OPTION |=> prescaler_cfg_reg == $past(acc_reg))
        else $error("prescaler config not loaded");
    a_soft_reset: assert property (op == LMX_OP_SWRESET
        |=> device_reset_reg && !reset_instruction_flag && !pc_advance_reg)
        else $error("software reset wrong");
    // the pulse cycle clears state but leaves the cause flag to software
    a_soft_clear: assert property (device_reset_reg
        |=> acc_reg == `LMX_RST_ACC && bank_select_reg == `LMX_RST_BANK
            && program_high_latch == `LMX_RST_PAGE && prescaler_cfg_reg == `LMX_RST_OPTION
            && ptr0_reg == `LMX_RST_PTR && ptr1_reg == `LMX_RST_PTR && !pc_advance_reg
            && status_reg == `LMX_RST_STATUS && !file_wr_reg.strobe && !device_reset_reg
            && (reset_instruction_flag == $past(reset_instruction_flag)
                || $past(ri_flag_set)))
        else $error("soft reset left state behind");
    a_idle_step: assert property (op == LMX_OP_IDLE
        |=> pc_advance_reg && !file_wr_reg.strobe && $stable(acc_reg)
            && $stable(ptr0_reg) && $stable(ptr1_reg))
        else $error("idle changed state");
    a_other_word: assert property (op == LMX_OP_OTHER
        |=> pc_advance_reg && !file_wr_reg.strobe && $stable(acc_reg)
            && $stable(bank_select_reg) && $stable(program_high_latch))
        else $error("unclassified word changed state");

    // main scenarios
    c_ind_store: cover property (op == LMX_OP_IND_MODE ##1 op == LMX_OP_IND_OFF);
    c_sw_reset: cover property (op == LMX_OP_SWRESET);
    c_acc_then_store: cover property (op == LMX_OP_ACC ##1 op == LMX_OP_DIRECT);
    c_ptr_wrap: cover property (op == LMX_OP_IND_MODE && ptr_cur == 16'hFFFF);
    c_window_store: cover property (op == LMX_OP_DIRECT && faddr == `LMX_WINDOW1_ADDR);

endmodule : lmx_exec

// ===== tb/literal_and_indirect_move_execution_test.sv
// Purpose: self-checking bench for the move execution block
// Assumes: one instruction taken per edge, effects visible one cycle later
// Notes: every instruction is followed by at least one idle cycle of valid low
`timescale 1ns/1ps
`include "lmx_consts.svh"
`define CHK(nm, ex, gt) cmp(nm, 16'(ex), 16'(gt))
module literal_and_indirect_move_execution_test;
    import lmx_pkg::*;

    // ****************************************************************
    // signals and bookkeeping
    // ****************************************************************
    logic ref_clk = 1'b0;
    logic sys_rst;
    lmx_instr_s instr_in;
    logic status_wr_en;
    logic [7:0] status_wr_data;
    logic ri_flag_set;
    logic [7:0] acc_reg;
    logic [4:0] bank_select_reg;
    logic [6:0] program_high_latch;
    logic [7:0] prescaler_cfg_reg;
    logic [15:0] ptr0_reg;
    logic [15:0] ptr1_reg;
    logic [7:0] status_reg;
    logic reset_instruction_flag;
    lmx_write_s file_wr_reg;
    logic pc_advance_reg;
    logic device_reset_reg;
    int n_fail = 0;
    int n_compared = 0;
    logic [15:0] mp [2]; // expected pointer values
    logic [7:0] st_exp;
    logic [7:0] acc_exp;
    localparam logic [1:0] MODE_SEQ [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};

    lmx_exec dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .instr_in(instr_in),
        .status_wr_en(status_wr_en),
        .status_wr_data(status_wr_data),
        .ri_flag_set(ri_flag_set),
        .acc_reg(acc_reg),
        .bank_select_reg(bank_select_reg),
        .program_high_latch(program_high_latch),
        .prescaler_cfg_reg(prescaler_cfg_reg),
        .ptr0_reg(ptr0_reg),
        .ptr1_reg(ptr1_reg),
        .status_reg(status_reg),
        .reset_instruction_flag(reset_instruction_flag),
        .file_wr_reg(file_wr_reg),
        .pc_advance_reg(pc_advance_reg),
        .device_reset_reg(device_reset_reg)
    );

    // clock, 40 ns period
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] gt);
        n_compared++;
        if (gt !== ex) begin
            $display("[ERR] %s expected %0h seen %0h", nm, ex, gt);
            n_fail++;
        end
    endtask : cmp

    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // one instruction, then checks on the pulses and flags
    task automatic exec(input logic [13:0] word, input logic strb);
        @(posedge ref_clk);
        #1;
        instr_in = {1'b1, word};
        @(posedge ref_clk);
        #1;
        instr_in = '0;
        `CHK("strobe", strb, file_wr_reg.strobe);
        `CHK("pc_advance", word != 14'h0001, pc_advance_reg);
        `CHK("status", st_exp, status_reg);
    endtask : exec

    // indirect store with a mode, tracking the pointer model
    task automatic ind(input int n, input logic [1:0] upd);
        logic [15:0] ea;
        logic [15:0] nx;
        case (upd)
            2'h0: begin nx = mp[n] + 16'h0001; ea = nx; end
            2'h1: begin nx = mp[n] - 16'h0001; ea = nx; end
            2'h2: begin ea = mp[n]; nx = ea + 16'h0001; end
            default: begin ea = mp[n]; nx = ea - 16'h0001; end
        endcase
        exec(14'h0018 | 14'(n << 2) | 14'(upd), 1'b1);
        mp[n] = nx;
        `CHK("ind_addr", ea, file_wr_reg.addr);
        `CHK("ind_data", acc_exp, file_wr_reg.data);
        `CHK("ptr0", mp[0], ptr0_reg);
        `CHK("ptr1", mp[1], ptr1_reg);
    endtask : ind

    // indirect store with a signed offset, pointer left alone
    task automatic off(input int n, input logic [5:0] k);
        exec(14'h3F80 | 14'(n << 6) | 14'(k), 1'b1);
        `CHK("off_addr", mp[n] + {{10{k[5]}}, k}, file_wr_reg.addr);
        `CHK("off_ptr", mp[n], n == 0 ? ptr0_reg : ptr1_reg);
    endtask : off

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_literals();
        exec(14'h0020 | 14'h0015, 1'b0);
        `CHK("bank", 5'h15, bank_select_reg);
        exec(14'h0020 | 14'h000A, 1'b0);
        `CHK("bank", 5'h0A, bank_select_reg);
        exec(14'h3180 | 14'h007F, 1'b0);
        `CHK("page", 7'h7F, program_high_latch);
        exec(14'h3000 | 14'h00FF, 1'b0);
        `CHK("acc", 8'hFF, acc_reg);
        exec(14'h3000 | 14'h005A, 1'b0);
        acc_exp = 8'h5A;
        `CHK("acc", acc_exp, acc_reg);
        exec(14'h0000, 1'b0);
        `CHK("idle_acc", acc_exp, acc_reg);
        `CHK("idle_bank", 5'h0A, bank_select_reg);
        `CHK("idle_page", 7'h7F, program_high_latch);
        exec(14'h2ABC, 1'b0);
        `CHK("other_acc", acc_exp, acc_reg);
        `CHK("other_bank", 5'h0A, bank_select_reg);
    endtask : t_literals

    task automatic t_direct();
        exec(14'h0080 | 14'h007F, 1'b1);
        `CHK("dir_addr", 16'h007F, file_wr_reg.addr);
        `CHK("dir_data", acc_exp, file_wr_reg.data);
        exec(14'h0062, 1'b0);
        `CHK("prescaler", acc_exp, prescaler_cfg_reg);
    endtask : t_direct

    task automatic t_window();
        ind(0, 2'h0);
        ind(1, 2'h1);
        exec(14'h0080 | 14'h0000, 1'b1);
        `CHK("win0_addr", mp[0], file_wr_reg.addr);
        exec(14'h0080 | 14'h0001, 1'b1);
        `CHK("win1_addr", mp[1], file_wr_reg.addr);
        `CHK("win_ptr0", mp[0], ptr0_reg);
    endtask : t_window

    task automatic t_reset();
        exec(14'h0001, 1'b0);
        `CHK("dev_reset", 1'b1, device_reset_reg);
        `CHK("ri_flag", 1'b0, reset_instruction_flag);
        @(posedge ref_clk);
        #1;
        `CHK("rst_acc", 8'h00, acc_reg);
        `CHK("rst_prescaler", 8'hFF, prescaler_cfg_reg);
        `CHK("rst_ptr1", 16'h0000, ptr1_reg);
        `CHK("rst_status", 8'h00, status_reg);
        `CHK("rst_pulse", 1'b0, device_reset_reg);
        `CHK("ri_flag_kept", 1'b0, reset_instruction_flag);
        ri_flag_set = 1'b1;
        @(posedge ref_clk);
        #1;
        ri_flag_set = 1'b0;
        `CHK("ri_flag_set", 1'b1, reset_instruction_flag);
    endtask : t_reset

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        instr_in = '0;
        sys_rst = 1'b1;
        status_wr_en = 1'b0;
        status_wr_data = 8'h00;
        ri_flag_set = 1'b0;
        mp[0] = 16'h0000;
        mp[1] = 16'h0000;
        st_exp = 8'h00;
        acc_exp = 8'h00;
        repeat (5) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        `CHK("init_prescaler", 8'hFF, prescaler_cfg_reg);
        `CHK("init_flag", 1'b1, reset_instruction_flag);
        // nonzero flags so any disturbance shows
        status_wr_en = 1'b1;
        status_wr_data = 8'hA5;
        @(posedge ref_clk);
        #1;
        status_wr_en = 1'b0;
        st_exp = 8'hA5;
        t_literals();
        t_direct();
        for (int n = 0; n < 2; n++) begin
            foreach (MODE_SEQ[i]) begin
                ind(n, MODE_SEQ[i]);
            end
            off(n, 6'h20);
            off(n, 6'h1F);
        end
        t_window();
        t_reset();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end

endmodule : literal_and_indirect_move_execution_test
